// ==== include/clse_pkg.sv ====
// Constants, field layouts and carrier types of the correlation, loop and
// sign-extension execution block.
// Assumes a 32-bit APB with byte addresses; every register is one aligned word.
package clse_pkg;

  // Sizes
  localparam int DATA_W      = 16;
  localparam int ACC_STR_W   = 48;
  localparam int NUM_IRQ     = 4;
  localparam int NUM_APTR    = 4;
  localparam int APTR_FLD_W  = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_INSTR      = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_CTRL       = 8'h08;
  localparam logic [7:0] OFS_PC         = 8'h0c;
  localparam logic [7:0] OFS_LOOP_COUNT = 8'h10;
  localparam logic [7:0] OFS_BUF_STEP   = 8'h14;
  localparam logic [7:0] OFS_COEF_PTR   = 8'h18;
  localparam logic [7:0] OFS_MULT_OPND  = 8'h1c;
  localparam logic [7:0] OFS_ACC_PTR    = 8'h20;
  localparam logic [7:0] OFS_LOOP_START = 8'h24;
  localparam logic [7:0] OFS_ACC_BASE   = 8'h40;
  localparam logic [7:0] OFS_AUX_BASE   = 8'h80;

  // Status word fields
  localparam int ST_SIGN    = 0;
  localparam int ST_CARRY   = 1;
  localparam int ST_ZERO    = 2;
  localparam int ST_BUSY    = 8;
  localparam int ST_LOOP    = 9;
  localparam int ST_REP     = 10;
  localparam int ST_PEND_LO = 12;
  // Control word fields
  localparam int CTRL_CIRC  = 0;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_PC   = 16'h0000;

  // Timing and steps
  localparam int          TAP_CYCLES     = 3;
  localparam logic [15:0] LOOP_STEP_ONE  = 16'h0001;
  localparam logic [15:0] LOOP_STEP_TWO  = 16'h0002;
  localparam logic [16:0] MIN_TAPS       = 17'h00002;

  typedef enum logic [3:0] {
    OP_NOP, OP_REPEAT, OP_RAM_CORR, OP_ROM_CORR,
    OP_LOOP_OPEN, OP_LOOP_CLOSE, OP_WORD_SEXT, OP_STR_SEXT
  } clse_op_t;

  // Instruction word written to the instruction register
  typedef struct packed {
    clse_op_t    op;
    logic [1:0]  an;
    logic [2:0]  rx;
    logic        post_inc;
    logic        step_two;
    logic        pre_mod;
    logic [3:0]  spare;
    logic [15:0] imm;
  } clse_instr_t;

  // Memory read request; data returns on the next cycle
  typedef struct packed {
    logic        sample_rd;
    logic [15:0] sample_addr;
    logic        coef_rd;
    logic        coef_prog;
    logic [15:0] coef_addr;
  } clse_mem_req_t;

endpackage

// ==== src/clse_exec.sv ====
// Execution unit for correlation taps, loop close and sign extension,
// driven by instruction words written over APB.
// Assumes sample and coefficient memories answer one cycle after a request.
//
// What this block does
// - repeated tap multiplies 16x16, accumulates 48 bits
// - each correlation tap takes three cycles
// - interrupts stay pending during correlation
// - circular flag adds step, else optional increment
// - result spans three consecutive accumulators
// - later coefficients come from coefficient pointer (ROM) or odd auxiliary register (RAM)
// - repeat N-2 gives N taps, first coefficient preloaded
// - repeat zero gives two-tap RAM correlation
// - nonnegative count: decrement by step, branch back
// - negative count: advance by one, leave loop
// - loop exit releases held interrupts by priority
// - loop close costs one cycle
// - loop close step defaults to one
// - word extension fills accumulator with sign flag
// - pointer modifier pre-increments accumulator pointer
// - string extension writes next accumulator with sign
// - string extension ignores repeat count, runs once
// - string extension keeps carry and zero flags
module clse_exec #(
  parameter int NUM_ACC = 16,
  parameter int NUM_AUX = 8
) (
  input  wire logic                    CLK_IN,
  input  wire logic                    RESET_IN,
  input  wire logic                    PSEL_IN,
  input  wire logic                    PENABLE_IN,
  input  wire logic                    PWRITE_IN,
  input  wire logic [7:0]              PADDR_IN,
  input  wire logic [31:0]             PWDATA_IN,
  output logic      [31:0]             PRDATA_OUT,
  output logic                         PREADY_OUT,
  output logic                         PSLVERR_OUT,
  output clse_pkg::clse_mem_req_t      MEM_REQ_OUT,
  input  wire logic [15:0]             MEM_SAMPLE_IN,
  input  wire logic [15:0]             MEM_COEF_IN,
  input  wire logic [3:0]              IRQ_IN,
  output logic                         IRQ_TAKE_OUT,
  output logic      [1:0]              IRQ_ID_OUT,
  output logic                         BUSY_OUT
);

  localparam int ACC_IDX_W = $clog2(NUM_ACC);
  localparam int AUX_IDX_W = $clog2(NUM_AUX);

  if (NUM_ACC < 4 || NUM_ACC > 16 || NUM_ACC != (1 << ACC_IDX_W)) begin : g_bad_acc
    $error("NUM_ACC must be a power of two from 4 to 16");
  end
  if (NUM_AUX < 2 || NUM_AUX > 8 || NUM_AUX != (1 << AUX_IDX_W)) begin : g_bad_aux
    $error("NUM_AUX must be 2, 4 or 8");
  end

  typedef enum {S_IDLE, S_FETCH, S_MUL, S_ACC} clse_state_t;

  function automatic logic fixed_hit(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= clse_pkg::OFS_LOOP_START;
  endfunction
  function automatic logic acc_hit(input logic [7:0] a);
    return a[7:6] == 2'b01 && a[1:0] == 2'b00 && int'(a[5:2]) < NUM_ACC;
  endfunction
  function automatic logic aux_hit(input logic [7:0] a);
    return a[7:5] == 3'b100 && a[1:0] == 2'b00 && int'(a[4:2]) < NUM_AUX;
  endfunction

  // Architectural state
  logic [15:0]            acc     [NUM_ACC];
  logic [15:0]            aux     [NUM_AUX];
  logic [ACC_IDX_W-1:0]   acc_ptr [clse_pkg::NUM_APTR];
  logic [15:0]            pc;
  logic [15:0]            loop_count_reg;
  logic [15:0]            buffer_step_reg;
  logic [15:0]            coef_pointer_reg;
  logic [15:0]            multiplier_operand_reg;
  logic [15:0]            loop_start;
  logic                   sign_flag;
  logic                   carry_flag;
  logic                   zero_flag;
  logic                   circ_flag;
  logic                   loop_hold;
  logic                   rep_armed;
  logic [15:0]            rep_count;
  logic [31:0]            last_instr;
  logic [clse_pkg::NUM_IRQ-1:0] pending;

  // Correlation engine
  clse_state_t            state;
  logic [16:0]            tap;
  logic [16:0]            last_tap;
  logic [ACC_IDX_W-1:0]   corr_base;
  logic [AUX_IDX_W-1:0]   corr_rx_even;
  logic                   corr_ram;
  logic                   corr_post_inc;
  logic signed [31:0]     product;
  logic [47:0]            acc_sum;
  clse_pkg::clse_mem_req_t mem_req;

  // Bus decode
  wire apb_setup    = PSEL_IN && !PENABLE_IN;
  wire apb_access   = PSEL_IN && PENABLE_IN;
  wire addr_ok      = fixed_hit(PADDR_IN) || acc_hit(PADDR_IN) || aux_hit(PADDR_IN);
  wire busy         = state != S_IDLE;
  wire instr_wr_hit = apb_access && PWRITE_IN && PADDR_IN == clse_pkg::OFS_INSTR;
  // Stall a new instruction until the taps finish
  assign PREADY_OUT  = !(instr_wr_hit && busy);
  assign PSLVERR_OUT = apb_access && !addr_ok;
  wire wr_en  = apb_access && PREADY_OUT && PWRITE_IN && addr_ok;
  wire wr_fix = wr_en && fixed_hit(PADDR_IN);
  wire [ACC_IDX_W-1:0] wr_acc_idx = PADDR_IN[ACC_IDX_W+1:2];
  wire [AUX_IDX_W-1:0] wr_aux_idx = PADDR_IN[AUX_IDX_W+1:2];

  // Instruction decode
  clse_pkg::clse_instr_t ins;
  assign ins = clse_pkg::clse_instr_t'(PWDATA_IN);
  wire issue     = wr_fix && PADDR_IN == clse_pkg::OFS_INSTR;
  wire is_corr   = ins.op == clse_pkg::OP_RAM_CORR || ins.op == clse_pkg::OP_ROM_CORR;
  wire do_corr   = issue && is_corr;
  wire do_wsext  = issue && ins.op == clse_pkg::OP_WORD_SEXT;
  wire do_ssext  = issue && ins.op == clse_pkg::OP_STR_SEXT;
  wire do_lopen  = issue && ins.op == clse_pkg::OP_LOOP_OPEN;
  wire do_lclose = issue && ins.op == clse_pkg::OP_LOOP_CLOSE;
  wire do_rep    = issue && ins.op == clse_pkg::OP_REPEAT;
  wire [ACC_IDX_W-1:0] ap_sel   = acc_ptr[ins.an];
  wire [ACC_IDX_W-1:0] ap_next  = ap_sel + ACC_IDX_W'(1);
  wire [ACC_IDX_W-1:0] sext_idx = (do_ssext || ins.pre_mod) ? ap_next : ap_sel;
  wire [AUX_IDX_W-1:0] ins_even = ins.rx[AUX_IDX_W-1:0] & ~AUX_IDX_W'(1);
  // Repeat N-2 yields N taps; no repeat still yields two
  wire [16:0] n_taps = rep_armed ? {1'b0, rep_count} + clse_pkg::MIN_TAPS
                                 : clse_pkg::MIN_TAPS;
  wire [15:0] loop_step = ins.step_two ? clse_pkg::LOOP_STEP_TWO
                                       : clse_pkg::LOOP_STEP_ONE;
  wire loop_go = !loop_count_reg[15];

  // Engine datapath
  wire [AUX_IDX_W-1:0] corr_rx_odd = corr_rx_even | AUX_IDX_W'(1);
  wire        eng_step = state == S_ACC;
  wire        eng_last = eng_step && tap == last_tap;
  wire        eng_adv  = eng_step && !eng_last;
  wire [15:0] rx_cur   = aux[corr_rx_even];
  wire [15:0] rx_inc   = circ_flag ? buffer_step_reg
                                   : (corr_post_inc ? 16'h0001 : 16'h0000);
  wire [15:0] rx_new   = rx_cur + rx_inc;
  wire [15:0] cptr_cur = corr_ram ? aux[corr_rx_odd] : coef_pointer_reg;
  // Pointer moves only once it has been used, so tap 1 reads the start address
  wire [15:0] cptr_new = cptr_cur + ((tap != 17'h00000) ? 16'h0001 : 16'h0000);
  wire [15:0] coef_op  = (tap == 17'h00000) ? multiplier_operand_reg : MEM_COEF_IN;
  logic [47:0] acc_sum_q;
  assign acc_sum = ((tap == 17'h00000) ? 48'h000000000000 : acc_sum_q)
                   + {{16{product[31]}}, product};

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state         <= S_IDLE;
      tap           <= 17'h00000;
      last_tap      <= 17'h00000;
      corr_base     <= '0;
      corr_rx_even  <= '0;
      corr_ram      <= 1'b0;
      corr_post_inc <= 1'b0;
      product       <= 32'sh00000000;
      acc_sum_q     <= 48'h000000000000;
      mem_req       <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (do_corr) begin
            state         <= S_FETCH;
            tap           <= 17'h00000;
            last_tap      <= n_taps - 17'h00001;
            corr_base     <= ap_sel;
            corr_rx_even  <= ins_even;
            corr_ram      <= ins.op == clse_pkg::OP_RAM_CORR;
            corr_post_inc <= ins.post_inc;
            mem_req       <= '{sample_rd: 1'b1, sample_addr: aux[ins_even],
                              coef_rd: 1'b0, coef_prog: 1'b0, coef_addr: 16'h0000};
          end
        end
        S_FETCH: begin
          state   <= S_MUL;
          mem_req <= '0;
        end
        S_MUL: begin
          state   <= S_ACC;
          product <= $signed(MEM_SAMPLE_IN) * $signed(coef_op);
        end
        S_ACC: begin
          acc_sum_q <= acc_sum;
          if (eng_last) begin
            state <= S_IDLE;
          end else begin
            state   <= S_FETCH;
            tap     <= tap + 17'h00001;
            mem_req <= '{sample_rd: 1'b1, sample_addr: rx_new, coef_rd: 1'b1,
                         coef_prog: !corr_ram, coef_addr: cptr_new};
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign MEM_REQ_OUT = mem_req;
  assign BUSY_OUT    = busy;

  // Auxiliary registers: engine pointer moves take priority over bus writes
  for (genvar i = 0; i < NUM_AUX; i++) begin : g_aux
    wire even_mv = eng_adv && corr_rx_even == AUX_IDX_W'(i);
    wire odd_mv  = eng_adv && corr_ram && corr_rx_odd == AUX_IDX_W'(i);
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        aux[i] <= clse_pkg::RST_WORD;
      end else if (even_mv) begin
        aux[i] <= rx_new;
      end else if (odd_mv) begin
        aux[i] <= cptr_new;
      end else if (wr_en && aux_hit(PADDR_IN) && wr_aux_idx == AUX_IDX_W'(i)) begin
        aux[i] <= PWDATA_IN[15:0];
      end
    end
  end

  // Accumulators
  for (genvar i = 0; i < NUM_ACC; i++) begin : g_acc
    wire [ACC_IDX_W-1:0] off = ACC_IDX_W'(i) - corr_base;
    wire corr_wr = eng_last && off < ACC_IDX_W'(3);
    wire sext_wr = (do_wsext || do_ssext) && sext_idx == ACC_IDX_W'(i);
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        acc[i] <= clse_pkg::RST_WORD;
      end else if (corr_wr) begin
        acc[i] <= acc_sum[off[1:0]*16 +: 16];
      end else if (sext_wr) begin
        acc[i] <= {16{sign_flag}};
      end else if (wr_en && acc_hit(PADDR_IN) && wr_acc_idx == ACC_IDX_W'(i)) begin
        acc[i] <= PWDATA_IN[15:0];
      end
    end
  end

  // Accumulator pointers
  for (genvar i = 0; i < clse_pkg::NUM_APTR; i++) begin : g_aptr
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        acc_ptr[i] <= '0;
      end else if (do_wsext && ins.pre_mod && ins.an == 2'(i)) begin
        acc_ptr[i] <= ap_next;
      end else if (wr_fix && PADDR_IN == clse_pkg::OFS_ACC_PTR) begin
        acc_ptr[i] <= PWDATA_IN[i*clse_pkg::APTR_FLD_W +: ACC_IDX_W];
      end
    end
  end

  // Sequencer: program counter, repeat, loop and plain registers
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pc                     <= clse_pkg::RST_PC;
      loop_count_reg         <= clse_pkg::RST_WORD;
      buffer_step_reg        <= clse_pkg::RST_WORD;
      coef_pointer_reg       <= clse_pkg::RST_WORD;
      multiplier_operand_reg <= clse_pkg::RST_WORD;
      loop_start             <= clse_pkg::RST_WORD;
      sign_flag              <= 1'b0;
      carry_flag             <= 1'b0;
      zero_flag              <= 1'b0;
      circ_flag              <= 1'b0;
      loop_hold              <= 1'b0;
      rep_armed              <= 1'b0;
      rep_count              <= clse_pkg::RST_WORD;
      last_instr             <= 32'h00000000;
    end else begin
      if (eng_adv && !corr_ram) begin
        coef_pointer_reg <= cptr_new;
      end else if (wr_fix && PADDR_IN == clse_pkg::OFS_COEF_PTR) begin
        coef_pointer_reg <= PWDATA_IN[15:0];
      end
      if (wr_fix && PADDR_IN == clse_pkg::OFS_BUF_STEP) begin
        buffer_step_reg <= PWDATA_IN[15:0];
      end
      if (wr_fix && PADDR_IN == clse_pkg::OFS_MULT_OPND) begin
        multiplier_operand_reg <= PWDATA_IN[15:0];
      end
      if (wr_fix && PADDR_IN == clse_pkg::OFS_CTRL) begin
        circ_flag <= PWDATA_IN[clse_pkg::CTRL_CIRC];
      end
      // Flags change only by software; no instruction here touches them
      if (wr_fix && PADDR_IN == clse_pkg::OFS_STATUS) begin
        sign_flag  <= PWDATA_IN[clse_pkg::ST_SIGN];
        carry_flag <= PWDATA_IN[clse_pkg::ST_CARRY];
        zero_flag  <= PWDATA_IN[clse_pkg::ST_ZERO];
      end
      if (issue) begin
        last_instr <= PWDATA_IN;
        // Repeat applies to the next instruction only
        rep_armed  <= do_rep;
        rep_count  <= ins.imm;
      end
      if (eng_last) begin
        pc <= pc + 16'h0001;
      end else if (do_lclose && loop_go) begin
        pc <= loop_start;
      end else if (issue && !do_corr) begin
        pc <= pc + 16'h0001;
      end else if (wr_fix && PADDR_IN == clse_pkg::OFS_PC) begin
        pc <= PWDATA_IN[15:0];
      end
      if (do_lclose && loop_go) begin
        loop_count_reg <= loop_count_reg - loop_step;
      end else if (wr_fix && PADDR_IN == clse_pkg::OFS_LOOP_COUNT) begin
        loop_count_reg <= PWDATA_IN[15:0];
      end
      if (do_lopen) begin
        loop_start <= pc + 16'h0001;
        loop_hold  <= 1'b1;
      end else if (do_lclose && !loop_go) begin
        loop_hold  <= 1'b0;
      end else if (wr_fix && PADDR_IN == clse_pkg::OFS_LOOP_START) begin
        loop_start <= PWDATA_IN[15:0];
      end
    end
  end

  // Interrupt queue: lowest index has highest priority
  wire irq_hold = busy || loop_hold || rep_armed;
  logic [clse_pkg::NUM_IRQ-1:0] grant;
  logic [1:0]                   grant_id;
  always_comb begin
    grant    = '0;
    grant_id = 2'h0;
    for (int i = clse_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (pending[i]) begin
        grant    = clse_pkg::NUM_IRQ'(1) << i;
        grant_id = 2'(i);
      end
    end
    if (irq_hold) begin
      grant = '0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pending      <= '0;
      IRQ_TAKE_OUT <= 1'b0;
      IRQ_ID_OUT   <= 2'h0;
    end else begin
      // A new request in the taking cycle stays pending
      pending      <= (pending & ~grant) | IRQ_IN;
      IRQ_TAKE_OUT <= |grant;
      IRQ_ID_OUT   <= grant_id;
    end
  end

  // Read mux, sampled in the setup phase so read data comes from flip-flops
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (acc_hit(PADDR_IN)) begin
      rd_mux[15:0] = acc[PADDR_IN[ACC_IDX_W+1:2]];
    end else if (aux_hit(PADDR_IN)) begin
      rd_mux[15:0] = aux[PADDR_IN[AUX_IDX_W+1:2]];
    end else begin
      case (PADDR_IN)
        clse_pkg::OFS_INSTR:      rd_mux = last_instr;
        clse_pkg::OFS_STATUS: begin
          rd_mux[clse_pkg::ST_SIGN]  = sign_flag;
          rd_mux[clse_pkg::ST_CARRY] = carry_flag;
          rd_mux[clse_pkg::ST_ZERO]  = zero_flag;
          rd_mux[clse_pkg::ST_BUSY]  = busy;
          rd_mux[clse_pkg::ST_LOOP]  = loop_hold;
          rd_mux[clse_pkg::ST_REP]   = rep_armed;
          rd_mux[clse_pkg::ST_PEND_LO +: clse_pkg::NUM_IRQ] = pending;
        end
        clse_pkg::OFS_CTRL:       rd_mux[clse_pkg::CTRL_CIRC] = circ_flag;
        clse_pkg::OFS_PC:         rd_mux[15:0] = pc;
        clse_pkg::OFS_LOOP_COUNT: rd_mux[15:0] = loop_count_reg;
        clse_pkg::OFS_BUF_STEP:   rd_mux[15:0] = buffer_step_reg;
        clse_pkg::OFS_COEF_PTR:   rd_mux[15:0] = coef_pointer_reg;
        clse_pkg::OFS_MULT_OPND:  rd_mux[15:0] = multiplier_operand_reg;
        clse_pkg::OFS_LOOP_START: rd_mux[15:0] = loop_start;
        clse_pkg::OFS_ACC_PTR: begin
          for (int i = 0; i < clse_pkg::NUM_APTR; i++) begin
            rd_mux[i*clse_pkg::APTR_FLD_W +: ACC_IDX_W] = acc_ptr[i];
          end
        end
        default:                  rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (apb_setup) begin
      PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : rd_mux;
    end
  end

endmodule

// ==== bench/clse_exec_asserts.sv ====
// Port-level checks for the correlation, loop and sign-extension block.
// Assumes it is bound to clse_exec; one clock domain, async reset high.
module clse_exec_asserts (
  input wire logic                    CLK_IN,
  input wire logic                    RESET_IN,
  input wire logic                    PSEL_IN,
  input wire logic                    PENABLE_IN,
  input wire logic                    PWRITE_IN,
  input wire logic [7:0]              PADDR_IN,
  input wire logic                    PREADY_OUT,
  input wire clse_pkg::clse_mem_req_t MEM_REQ_OUT,
  input wire logic                    IRQ_TAKE_OUT,
  input wire logic                    BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  int busy_cnt;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) busy_cnt <= 0;
    else busy_cnt <= BUSY_OUT ? busy_cnt + 1 : 0;
  end

  sequence start_s;
    $rose(BUSY_OUT);
  endsequence
  sequence tap_s;
    MEM_REQ_OUT.sample_rd ##1 !MEM_REQ_OUT.sample_rd ##1 !MEM_REQ_OUT.sample_rd;
  endsequence

  a_tap_three: assert property (start_s |-> tap_s)
    else $error("tap did not take three cycles");
  a_sample_spacing: assert property (MEM_REQ_OUT.sample_rd |-> tap_s)
    else $error("sample reads closer than three cycles");
  a_busy_length: assert property ($fell(BUSY_OUT) |-> busy_cnt % 3 == 0 && busy_cnt >= 6)
    else $error("busy span not a whole number of taps");
  a_irq_held: assert property (BUSY_OUT && $past(BUSY_OUT) |-> !IRQ_TAKE_OUT)
    else $error("interrupt taken during correlation");
  a_first_coef: assert property (start_s |-> !MEM_REQ_OUT.coef_rd)
    else $error("coefficient read in first tap");
  a_later_coef: assert property (start_s ##3 MEM_REQ_OUT.sample_rd |-> MEM_REQ_OUT.coef_rd)
    else $error("second tap read no coefficient");
  a_no_idle_req: assert property (!BUSY_OUT |-> !MEM_REQ_OUT.sample_rd && !MEM_REQ_OUT.coef_rd)
    else $error("memory read while idle");
  a_ready_idle: assert property (!BUSY_OUT && PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("wait state while idle");
  a_ready_busy: assert property (BUSY_OUT && PSEL_IN && PENABLE_IN && PWRITE_IN
      && PADDR_IN == clse_pkg::OFS_INSTR |-> !PREADY_OUT)
    else $error("instruction accepted while busy");
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for clse_exec, driving APB and answering memory reads.
// Assumes memories answer one cycle after a read pulse.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk, rst, psel, penable, pwrite, pready, pslverr, take, busy;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata;
  logic [15:0]            smp, cof, s_nx, c_nx;
  logic [3:0]             irq;
  logic [1:0]             irq_id, last_id;
  logic                   last_prog;
  clse_pkg::clse_mem_req_t mreq;
  int                     miscompares, checked, takes;

  clse_exec u_dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MEM_REQ_OUT(mreq), .MEM_SAMPLE_IN(smp),
    .MEM_COEF_IN(cof), .IRQ_IN(irq), .IRQ_TAKE_OUT(take), .IRQ_ID_OUT(irq_id),
    .BUSY_OUT(busy));

  function automatic logic [15:0] sv(input logic [15:0] a);
    return a ^ 16'h8a51;
  endfunction
  function automatic logic [15:0] cv(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'hc3f0;
  endfunction
  function automatic logic [63:0] prod(input logic [15:0] h, input logic [15:0] x);
    return longint'($signed(h)) * longint'($signed(x));
  endfunction
  function automatic logic [31:0] ins(input clse_pkg::clse_op_t op, input logic [1:0] an,
      input logic [2:0] rx, input logic [2:0] mods, input logic [15:0] imm);
    return {op, an, rx, mods, 4'h0, imm};
  endfunction

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Idle lines toggle so stale data is never mistaken for an answer
  always @(negedge clk) begin
    s_nx <= mreq.sample_rd ? sv(mreq.sample_addr) : ~smp;
    c_nx <= mreq.coef_rd ? cv(mreq.coef_addr) : ~cof;
    if (mreq.coef_rd === 1'b1) last_prog <= mreq.coef_prog;
    if (take === 1'b1) begin
      takes <= takes + 1;
      last_id <= irq_id;
    end
  end
  always @(posedge clk) begin
    smp <= s_nx;
    cof <= c_nx;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic acc_chk(input logic [7:0] a0, a1, a2, input logic [63:0] s);
    rd_chk(a0, {16'h0, s[15:0]});
    rd_chk(a1, {16'h0, s[31:16]});
    rd_chk(a2, {16'h0, s[47:32]});
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rd_chk(clse_pkg::OFS_STATUS, 32'h0);
    rd_chk(clse_pkg::OFS_ACC_PTR, 32'h0);
    apb(1'b0, 8'h2c, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  task automatic t_rom_corr;
    int          n, t0;
    logic [63:0] s;
    wr(clse_pkg::OFS_AUX_BASE, 32'h0100);
    wr(clse_pkg::OFS_COEF_PTR, 32'h0200);
    wr(clse_pkg::OFS_MULT_OPND, 32'h8001);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_REPEAT, 2'h0, 3'h0, 3'h0, 16'h0001));
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_ROM_CORR, 2'h0, 3'h0, 3'h4, 16'h0));
    t0 = takes;
    irq <= 4'h4;
    wait_idle(n);
    @(posedge clk) irq <= 4'h0;
    chk(n, 9);
    repeat (4) @(posedge clk);
    chk({31'h0, takes > t0}, 32'h1);
    chk(last_id, 2'h2);
    s = prod(16'h8001, sv(16'h100)) + prod(cv(16'h200), sv(16'h101))
      + prod(cv(16'h201), sv(16'h102));
    acc_chk(8'h40, 8'h44, 8'h48, s);
    rd_chk(clse_pkg::OFS_AUX_BASE, 32'h0102);
    rd_chk(clse_pkg::OFS_COEF_PTR, 32'h0201);
    chk(last_prog, 1'b1);
    rd_chk(clse_pkg::OFS_PC, 32'h2);
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic t_ram_corr;
    wr(clse_pkg::OFS_CTRL, 32'h1);
    wr(clse_pkg::OFS_BUF_STEP, 32'h3);
    wr(8'h88, 32'h0300);
    wr(8'h8c, 32'h0400);
    wr(clse_pkg::OFS_ACC_PTR, 32'h00e0);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_REPEAT, 2'h0, 3'h0, 3'h0, 16'h0));
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_RAM_CORR, 2'h1, 3'h2, 3'h0, 16'h0));
    // Held in wait state until the engine finishes
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_NOP, 2'h0, 3'h0, 3'h0, 16'h0));
    acc_chk(8'h78, 8'h7c, 8'h40, prod(16'h8001, sv(16'h300)) + prod(cv(16'h400), sv(16'h303)));
    rd_chk(8'h88, 32'h0303);
    rd_chk(8'h8c, 32'h0400);
    chk(last_prog, 1'b0);
    rd_chk(clse_pkg::OFS_PC, 32'h5);
  endtask

  task automatic t_loop;
    int t0;
    t0 = takes;
    wr(clse_pkg::OFS_LOOP_COUNT, 32'h1);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_LOOP_OPEN, 2'h0, 3'h0, 3'h0, 16'h0));
    irq <= 4'h2;
    @(posedge clk);
    irq <= 4'h0;
    for (int i = 0; i < 2; i++) begin
      wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_LOOP_CLOSE, 2'h0, 3'h0, 3'h0, 16'h0));
      rd_chk(clse_pkg::OFS_PC, 32'h6);
    end
    rd_chk(clse_pkg::OFS_LOOP_COUNT, 32'hffff);
    chk(takes, t0);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_LOOP_CLOSE, 2'h0, 3'h0, 3'h0, 16'h0));
    rd_chk(clse_pkg::OFS_PC, 32'h7);
    chk(takes, t0 + 1);
    chk(last_id, 2'h1);
    wr(clse_pkg::OFS_LOOP_COUNT, 32'h5);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_LOOP_CLOSE, 2'h0, 3'h0, 3'h2, 16'h0));
    rd_chk(clse_pkg::OFS_LOOP_COUNT, 32'h3);
    rd_chk(clse_pkg::OFS_PC, 32'h6);
  endtask

  task automatic t_sext;
    wr(clse_pkg::OFS_STATUS, 32'h3);
    wr(clse_pkg::OFS_ACC_PTR, 32'h0400);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_WORD_SEXT, 2'h2, 3'h0, 3'h0, 16'h0));
    rd_chk(8'h50, 32'hffff);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_WORD_SEXT, 2'h2, 3'h0, 3'h1, 16'h0));
    rd_chk(8'h54, 32'hffff);
    rd_chk(clse_pkg::OFS_ACC_PTR, 32'h0500);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_REPEAT, 2'h0, 3'h0, 3'h0, 16'h0007));
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_STR_SEXT, 2'h2, 3'h0, 3'h0, 16'h0));
    rd_chk(8'h58, 32'hffff);
    rd_chk(8'h5c, 32'h0);
    rd_chk(clse_pkg::OFS_STATUS, 32'h3);
    wr(clse_pkg::OFS_STATUS, 32'h2);
    wr(clse_pkg::OFS_INSTR, ins(clse_pkg::OP_WORD_SEXT, 2'h2, 3'h0, 3'h0, 16'h0));
    rd_chk(8'h54, 32'h0);
    rd_chk(clse_pkg::OFS_PC, 32'hb);
  endtask

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, irq} = '0;
    {miscompares, checked, takes} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rom_corr();
    t_ram_corr();
    t_loop();
    t_sext();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule

bind clse_exec clse_exec_asserts u_chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
  .MEM_REQ_OUT(MEM_REQ_OUT), .IRQ_TAKE_OUT(IRQ_TAKE_OUT), .BUSY_OUT(BUSY_OUT));
